// ### lpdc_pkg.sv
/*
 * Package for the LCD pin select and display control block: register
 * offsets, field positions, reset values and the pin-map carrier struct.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package lpdc_pkg;

	// Byte offsets on the register bus
	localparam logic [7:0] PIN_CTRL_OFS  = 8'h00;
	localparam logic [7:0] RAM_OR_BLANK_SELECT_CTRL_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS    = 8'h08;

	// Pin function control fields
	localparam int EXP_SEL_BIT  = 4;
	localparam int GRP_SEL_LSB  = 0;
	localparam int GRP_SEL_W    = 4;
	localparam int PIN_CTRL_W   = 8;
	localparam logic [7:0] PIN_CTRL_RST = 8'h00;

	// Display control fields
	localparam int DC_RSVD_BIT   = 7;
	localparam int DC_SUPPLY_BIT = 6;
	localparam int DC_RUN_BIT    = 5;
	localparam int DC_SRC_BIT    = 4;
	localparam int DC_FRAME_LSB  = 0;
	localparam logic [7:0] RAM_OR_BLANK_SELECT_CTRL_RST = 8'h80;

	// Segment pin map
	localparam int NUM_SEG   = 40;
	localparam int GRP_PINS  = 8;
	localparam int NUM_EXP   = 4;

	// Per-pin function as seen at the pad mux
	typedef struct packed {
		logic [NUM_SEG-1:0] seg_en;   // Pin drives LCD segment
		logic [NUM_SEG-1:0] port_en;  // Pin is a general port
		logic [NUM_EXP-1:0] exp_en;   // Pins 40..37 carry expansion
	} lpdc_pinmap_s;

	// Expansion-side signals from the timing core
	typedef struct packed {
		logic latch_clock_out;
		logic shift_clock_out;
		logic serial_data;
		logic alternating;
	} lpdc_exp_s;

endpackage : lpdc_pkg

// ### lpdc_pin_decode.sv
/*
 * Pin function decoder: turns expansion select and group select into
 * per-pin segment, port and expansion enables.
 * Assumes registered inputs; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

module lpdc_pin_decode (
	// Control fields
	input  wire logic                   expansion_select,
	input  wire logic [3:0]             segment_group_select,
	// Pin map
	output lpdc_pkg::lpdc_pinmap_s      pinmap
);

	logic [2:0] groups_on;

	// Number of top groups in segment mode
	always_comb begin
		if (expansion_select) begin
			groups_on = 3'd0;
		end else if (segment_group_select[3]) begin
			groups_on = 3'd5;
		end else if (segment_group_select[2:1] != 2'b00) begin
			groups_on = {1'b0, segment_group_select[2:1]} + 3'd1;
		end else if (segment_group_select[0]) begin
			groups_on = 3'd1;
		end else begin
			groups_on = 3'd0;
		end
	end

	always_comb begin
		pinmap = '0;
		for (int i = 0; i < lpdc_pkg::NUM_SEG; i++) begin
			// Group 0 is pins 40..33, the top of the vector
			if ((lpdc_pkg::NUM_SEG - 1 - i) / lpdc_pkg::GRP_PINS
				< int'(groups_on)) begin
				pinmap.seg_en[i] = 1'b1;
			end
		end
		if (expansion_select) begin
			pinmap.exp_en = '1;
			pinmap.seg_en[39:36] = 4'b0000;
		end
		pinmap.port_en = ~pinmap.seg_en;
		if (expansion_select) begin
			pinmap.port_en[39:36] = 4'b0000;
		end
	end

endmodule : lpdc_pin_decode

`default_nettype wire

// ### lpdc_top.sv
/*
 * LCD pin select and display control: AHB-Lite register slave holding the
 * pin function and display control registers, plus the segment pad mux.
 * Assumes a single clock, a synchronous reset, and a frame timing core
 * outside that supplies segment data and expansion signals.
 */
// Function
// - Expansion select swaps top four pins
// - Reset state: all forty pins are ports
// - Group select enables segments eight at a time
// - Expansion with zero groups: pins 40-37 expansion
// - Display control resets 0x80, top bit 1
// - Supply switch bit turns drive power on
// - Supply forced off if halted or standby
// - Clearing run bit halts controller, registers retained
// - Source bit selects RAM or blank data
// - Pins 40..37 carry latch, shift, data, alternating
`timescale 1ns/100ps
`default_nettype none

module lpdc_top (
	// System
	input  wire logic                 clk,
	input  wire logic                 srst,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// Chip state
	input  wire logic                 standby,
	// From frame timing core
	input  wire logic [39:0]          seg_data_in,
	input  wire lpdc_pkg::lpdc_exp_s  exp_in,
	// Port function data for pins in port mode
	input  wire logic [39:0]          port_out_in,
	input  wire logic [39:0]          port_oe_in,
	// Pad side
	output logic      [39:0]          seg_pad_out,
	output logic      [39:0]          seg_pad_oe,
	output logic      [39:0]          seg_drive_en,
	// Control out to timing core and supply
	output logic                      controller_run,
	output logic                      drive_supply_on,
	output logic                      ram_or_blank_select,
	output logic      [3:0]           frame_clock_select
);

	// Register state
	logic [7:0]  pin_ctrl_reg;
	logic [6:0]  ram_or_blank_select_ctrl_reg;
	// Write data phase bookkeeping
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	// Read address phase decode
	logic [7:0]  rd_addr;
	logic        rd_take;
	// Register fields by name
	logic        exp_sel;
	logic [3:0]  grp_sel;
	logic        supply_sw;
	logic        run_bit;
	logic        src_bit;
	// Pad mux result, registered below
	logic [39:0] seg_pad_next;
	logic [39:0] oe_next;
	logic [39:0] drive_next;
	lpdc_pkg::lpdc_pinmap_s pinmap;

	// Byte offset within the block's decode window
	function automatic logic [7:0] word_ofs(input logic [31:0] a);
		word_ofs = {a[7:2], 2'b00};
	endfunction : word_ofs

	// Data phase of a write that targets the given offset
	function automatic logic write_hits(
		input logic       pend,
		input logic [7:0] wofs,
		input logic [7:0] ofs
	);
		write_hits = pend && (wofs == ofs);
	endfunction : write_hits

	// Zero-wait-state slave, always OKAY
	// Only whole words are used, so hsize is not decoded
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Capture write address phase; data arrives next cycle
	// A read issued in a write's data phase sees the old value
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (hready) begin
			wr_pend_reg <= hsel & htrans[1] & hwrite;
			wr_addr_reg <= word_ofs(haddr);
		end
	end

	// Pin function control register
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_ctrl_reg <= lpdc_pkg::PIN_CTRL_RST;
		end else if (write_hits(wr_pend_reg, wr_addr_reg,
			lpdc_pkg::PIN_CTRL_OFS)) begin
			pin_ctrl_reg <= hwdata[lpdc_pkg::PIN_CTRL_W-1:0];
		end
	end

	// Display control; top bit is constant and not stored
	always_ff @(posedge clk) begin
		if (srst) begin
			ram_or_blank_select_ctrl_reg <=
				lpdc_pkg::RAM_OR_BLANK_SELECT_CTRL_RST[lpdc_pkg::DC_RSVD_BIT-1:0];
		end else if (write_hits(wr_pend_reg, wr_addr_reg,
			lpdc_pkg::RAM_OR_BLANK_SELECT_CTRL_OFS)) begin
			// Clearing run leaves pin_ctrl_reg as is; seg_drive_en clears
			ram_or_blank_select_ctrl_reg <= hwdata[lpdc_pkg::DC_RSVD_BIT-1:0];
		end
	end

	// Read data registered during the address phase
	assign rd_addr = word_ofs(haddr);
	assign rd_take = hready && hsel && htrans[1] && !hwrite;
	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_take) begin
			unique case (rd_addr)
				lpdc_pkg::PIN_CTRL_OFS:
					hrdata <= {24'h00_0000, pin_ctrl_reg};
				lpdc_pkg::RAM_OR_BLANK_SELECT_CTRL_OFS:
					hrdata <= {24'h00_0000, 1'b1, ram_or_blank_select_ctrl_reg};
				lpdc_pkg::STATUS_OFS:
					hrdata <= {29'h0000_0000, standby,
						drive_supply_on, controller_run};
				default:
					hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Register fields by name
	assign exp_sel   = pin_ctrl_reg[lpdc_pkg::EXP_SEL_BIT];
	assign grp_sel   = pin_ctrl_reg[lpdc_pkg::GRP_SEL_LSB
		+: lpdc_pkg::GRP_SEL_W];
	assign supply_sw = ram_or_blank_select_ctrl_reg[lpdc_pkg::DC_SUPPLY_BIT];
	assign run_bit   = ram_or_blank_select_ctrl_reg[lpdc_pkg::DC_RUN_BIT];
	assign src_bit   = ram_or_blank_select_ctrl_reg[lpdc_pkg::DC_SRC_BIT];

	// Control outputs
	assign controller_run      = run_bit;
	assign ram_or_blank_select = src_bit;
	assign frame_clock_select  = ram_or_blank_select_ctrl_reg[lpdc_pkg::DC_FRAME_LSB +: 4];
	// Halt or standby overrides the supply switch
	assign drive_supply_on = supply_sw
		& run_bit & ~standby;

	lpdc_pin_decode u_decode (
		.expansion_select     (exp_sel),
		.segment_group_select (grp_sel),
		.pinmap               (pinmap)
	);

	// Pad mux
	always_comb begin
		for (int i = 0; i < 40; i++) begin
			if (pinmap.seg_en[i]) begin
				// Blank unless running and RAM selected
				seg_pad_next[i] = seg_data_in[i] & controller_run
					& ram_or_blank_select;
				oe_next[i] = 1'b1;
			end else if (pinmap.port_en[i]) begin
				seg_pad_next[i] = port_out_in[i];
				oe_next[i]      = port_oe_in[i];
			end else begin
				seg_pad_next[i] = 1'b0;
				oe_next[i]      = 1'b1;
			end
		end
		if (pinmap.exp_en[3]) begin
			seg_pad_next[39] = exp_in.latch_clock_out;
			seg_pad_next[38] = exp_in.shift_clock_out;
			seg_pad_next[37] = exp_in.serial_data & ram_or_blank_select;
			seg_pad_next[36] = exp_in.alternating;
		end
	end

	// Registered pad data avoids glitches on mode change
	always_ff @(posedge clk) begin
		if (srst) begin
			seg_pad_out <= 40'h00_0000_0000;
		end else begin
			seg_pad_out <= seg_pad_next;
		end
	end

	// Pad enables: ports drive nothing until told to
	always_ff @(posedge clk) begin
		if (srst) begin
			seg_pad_oe <= 40'h00_0000_0000;
		end else begin
			seg_pad_oe <= oe_next;
		end
	end

	// Segment drive only while the controller runs
	assign drive_next = pinmap.seg_en & {40{run_bit}};
	always_ff @(posedge clk) begin
		if (srst) begin
			seg_drive_en <= 40'h00_0000_0000;
		end else begin
			seg_drive_en <= drive_next;
		end
	end

endmodule : lpdc_top

`default_nettype wire

// ### lpdc_top_properties.sv
/* Port checker for lpdc_top.
   Assumes it is bound to lpdc_top with one clock and sync reset. */
`timescale 1ns/100ps
`default_nettype none
module lpdc_chk (
	// System and bus
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	// Control and pads
	input wire logic        standby,
	input wire logic [39:0] seg_data_in,
	input wire logic [39:0] seg_pad_out,
	input wire logic [39:0] seg_drive_en,
	input wire logic        controller_run,
	input wire logic        drive_supply_on,
	input wire logic        ram_or_blank_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_dc(w);
		hsel && hready && htrans[1] && hwrite == w
		&& haddr[7:0] == lpdc_pkg::RAM_OR_BLANK_SELECT_CTRL_OFS;
	endsequence
	a_supply_forced_off: assert property (!controller_run || standby
		|-> !drive_supply_on) else $error("supply on while halted");
	a_supply_write: assert property (s_dc(1) ##1 1 |=> drive_supply_on
		== ($past(hwdata[6]) && controller_run && !standby))
		else $error("supply does not follow write");
	a_run_write: assert property (s_dc(1) ##1 1 |=>
		controller_run == $past(hwdata[5])) else $error("run bit lost");
	a_halt_no_drive: assert property (!controller_run |=>
		seg_drive_en == '0) else $error("segments driven while halted");
	a_blank_data: assert property (!ram_or_blank_select |=>
		(seg_pad_out & seg_drive_en) == '0) else $error("not blank");
	a_ram_shown: assert property (ram_or_blank_select |=>
		(seg_pad_out & seg_drive_en) == ($past(seg_data_in) & seg_drive_en))
		else $error("segment data wrong");
	a_group_shape: assert property (seg_drive_en inside {40'h0,
		40'hff_0000_0000, 40'hff_ff00_0000, 40'hff_ffff_0000,
		40'hff_ffff_ff00, 40'hff_ffff_ffff}) else $error("bad group");
	a_reserved_one: assert property (s_dc(0) |=> hrdata[7])
		else $error("reserved bit reads 0");
endmodule : lpdc_chk
bind lpdc_top lpdc_chk i_lpdc_chk (.clk, .srst, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hrdata, .standby, .seg_data_in, .seg_pad_out,
	.seg_drive_en, .controller_run, .drive_supply_on, .ram_or_blank_select);
`default_nettype wire

// ### lpdc_panel_model.sv
/* Expansion driver model: shifts serial data, latches a byte.
   Assumes pads registered on clk, driven while oe is high. */
`timescale 1ns/100ps
`default_nettype none
module lpdc_panel_model (
	// Pads
	input wire logic        clk,
	input wire logic [39:0] seg_pad_out,
	input wire logic [39:0] seg_pad_oe,
	// Latched byte
	output logic     [7:0]  shifted_byte
);
	logic [7:0] sr_reg;
	logic       sh_reg;
	logic       lt_reg;
	initial shifted_byte = 8'h00;
	always @(posedge clk) begin
		sh_reg <= seg_pad_out[38];
		lt_reg <= seg_pad_out[39];
		if (&seg_pad_oe[39:37] && seg_pad_out[38] && !sh_reg)
			sr_reg <= {sr_reg[6:0], seg_pad_out[37]};
		if (seg_pad_out[39] && !lt_reg)
			shifted_byte <= sr_reg;
	end
endmodule : lpdc_panel_model
`default_nettype wire

// ### lpdc_pin_select_and_display_control_tb.sv
/* Self-checking bench for lpdc_top with expansion driver model.
   Assumes 40 MHz clock and AHB-Lite word registers. */
`timescale 1ns/100ps
`default_nettype none
module lpdc_pin_select_and_display_control_tb;
	logic clk = 0, srst = 1, hsel = 0, hwrite = 0, standby = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'b010;
	logic hreadyout, controller_run, drive_supply_on, ram_or_blank_select;
	logic [39:0] seg_data_in = 40'ha5_5a3c_c3f0, port_out_in = 40'h12_3456_789a;
	logic [39:0] port_oe_in = 40'hff_0000_ffff, seg_pad_out, seg_pad_oe;
	logic [39:0] seg_drive_en, m;
	logic [7:0] rx;
	logic hresp;
	logic [3:0] fcs;
	lpdc_pkg::lpdc_exp_s exp_in = '0;
	int n_mismatch = 0, n_checks = 0;
	lpdc_top i_lpdc_top (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .standby,
		.seg_data_in, .exp_in, .port_out_in, .port_oe_in, .seg_pad_out,
		.seg_pad_oe, .seg_drive_en, .controller_run, .drive_supply_on,
		.ram_or_blank_select, .frame_clock_select(fcs));
	lpdc_panel_model i_lpdc_panel_model (.clk, .seg_pad_out, .seg_pad_oe,
		.shifted_byte(rx));
	initial forever #12.5 clk = ~clk;
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 0; htrans <= 0; hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
		repeat (2) @(posedge clk);
		#1;
	endtask : bus
	task automatic t_regs;
		check(seg_drive_en, 0);
		check(seg_pad_out, port_out_in);
		check(seg_pad_oe, port_oe_in);
		bus(0, 8'h04, 0); check(q, 40'h80);
		bus(1, 8'h04, 8'h0f); bus(0, 8'h04, 0); check(q, 40'h8f);
		check(fcs, 4'hf);
		check(hresp, 0);
		bus(0, 8'h0c, 0); check(q, 0);
	endtask : t_regs
	task automatic t_groups;
		logic [3:0] c [5] = '{4'h1, 4'h3, 4'h4, 4'h7, 4'hf};
		bus(1, 8'h04, 8'h30);
		for (int n = 1; n <= 5; n++) begin
			bus(1, 8'h00, {4'h0, c[n-1]});
			m = ~(40'hff_ffff_ffff >> (8 * n));
			check(seg_drive_en, m);
			check(seg_pad_out, (seg_data_in & m) | (port_out_in & ~m));
		end
	endtask : t_groups
	task automatic t_expansion;
		logic [7:0] b = 8'hc6;
		bus(1, 8'h00, 8'h10);
		@(posedge clk) exp_in <= 4'b1001;
		bus(0, 8'h00, 0);
		check(seg_pad_out[39:36], 4'h9);
		check(seg_pad_oe[39:36], 4'hf);
		check(seg_pad_out[35:0], port_out_in[35:0]);
		check(seg_drive_en, 0);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk) exp_in <= {2'b00, b[i], 1'b0};
			@(posedge clk) exp_in.shift_clock_out <= 1'b1;
			@(posedge clk) exp_in.shift_clock_out <= 1'b0;
		end
		@(posedge clk) exp_in.latch_clock_out <= 1'b1;
		repeat (4) @(posedge clk);
		check(rx, b);
	endtask : t_expansion
	task automatic t_supply;
		bus(1, 8'h00, 8'h08); bus(1, 8'h04, 8'h50);
		check(drive_supply_on, 0);
		bus(1, 8'h04, 8'h70); check(drive_supply_on, 1);
		check(seg_pad_out, seg_data_in);
		@(posedge clk) standby <= 1;
		bus(0, 8'h04, 0); check(drive_supply_on, 0);
		bus(0, 8'h08, 0); check(q, 40'h05);
		@(posedge clk) standby <= 0;
		bus(1, 8'h04, 8'h60); check(seg_pad_out, 0);
		bus(1, 8'h04, 8'h40); check(seg_drive_en, 0);
		bus(0, 8'h04, 0); check(q, 40'hc0);
		bus(0, 8'h00, 0); check(q, 40'h08);
	endtask : t_supply
	task automatic summarize;
		$display("mismatches %0d checks %0d", n_mismatch, n_checks);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	initial begin
		#(25 * 20000);
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 0;
		repeat (2) @(posedge clk);
		#1;
		t_regs(); t_groups(); t_expansion(); t_supply();
		summarize();
	end
endmodule : lpdc_pin_select_and_display_control_tb
`default_nettype wire
